/* core/uart_mode_pkg.sv */
package uart_mode_pkg;
   // Register byte addresses on the plain register port.
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;
   localparam logic [7:0] ADDR_OPORT = 8'h10;
   // Reset values.
   localparam logic [7:0] MODE_ONE_RST = 8'h00;
   localparam logic [7:0] MODE_TWO_RST = 8'h00;
   localparam logic [3:0] CTRL_RST = 4'h0;
   // Mode register two field positions.
   localparam int CHMODE_LSB = 6;
   localparam int RTS_CTL_BIT = 5;
   localparam int CTS_CTL_BIT = 4;
   localparam int STOP_MSB = 3;
   // Channel mode encodings.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_ECHO = 2'h1;
   localparam logic [1:0] MODE_LOCAL = 2'h2;
   localparam logic [1:0] MODE_REMOTE = 2'h3;
   // Control register bits.
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_EXT1X = 2;
   localparam int CTRL_PTR_RST = 3;
   // Timing: the 16x tick comes from the 100 MHz clock.
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_HZ = 115_200;
   localparam int TICK_DIV = CLK_HZ / (16 * BAUD_HZ);
   localparam logic [5:0] BIT_TICKS = 6'h10;
   localparam logic [5:0] HALF_TICKS = 6'h08;
   localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
   localparam logic [5:0] STOP_LONG_BASE = 6'h19;
   localparam logic [5:0] FIVE_BIT_EXTRA = 6'h08;
   // One-hot state codes shared by both directions.
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_START = 5'b00010,
      ST_DATA = 5'b00100,
      ST_PAR = 5'b01000,
      ST_STOP = 5'b10000
   } frame_state_t;
endpackage

/* core/rx_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Carries the receive line, framing settings and received results.
interface rx_link_if;
   logic tick;
   logic line;
   logic [1:0] char_len;
   logic parity_en;
   logic parity_odd;
   logic [7:0] data;
   logic valid;
   logic parity_err;
   logic frame_err;
   modport main (output tick, line, char_len, parity_en, parity_odd,
      input data, valid, parity_err, frame_err);
   modport rx (input tick, line, char_len, parity_en, parity_odd,
      output data, valid, parity_err, frame_err);
endinterface
`default_nettype wire

/* core/uart_rx_frame.sv */
`timescale 1ns/10ps
`default_nettype none
// Receiver that samples each bit at its centre from the 16x tick.
module uart_rx_frame (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Link to the channel.
   rx_link_if.rx lnk
);
   uart_mode_pkg::frame_state_t state_reg;
   logic [5:0] cnt_reg; // Ticks left to the next sample point.
   logic [2:0] bitn_reg; // Index of the data bit being sampled.
   logic [7:0] shift_reg; // Assembled character, LSB first.
   logic par_reg; // Running parity of the data bits.
   wire last_bit = (bitn_reg == {1'b0, lnk.char_len} + 3'd4);
   wire at_point = lnk.tick && (cnt_reg == 6'h00);
   wire [7:0] data_next = {lnk.line, shift_reg[7:1]};

   // The frame walker; data shift by the character length at the end.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= uart_mode_pkg::ST_IDLE;
         cnt_reg <= 6'h00;
         bitn_reg <= 3'h0;
         shift_reg <= 8'h00;
         par_reg <= 1'b0;
         lnk.valid <= 1'b0;
         lnk.data <= 8'h00;
         lnk.parity_err <= 1'b0;
         lnk.frame_err <= 1'b0;
      end else begin
         lnk.valid <= 1'b0;
         unique case (state_reg)
            uart_mode_pkg::ST_IDLE: begin
               // A falling line opens a start bit, checked at its centre.
               if (lnk.tick && !lnk.line) begin
                  state_reg <= uart_mode_pkg::ST_START;
                  cnt_reg <= uart_mode_pkg::HALF_TICKS - 6'h02;
               end
            end
            uart_mode_pkg::ST_START: begin
               if (lnk.tick) cnt_reg <= cnt_reg - 6'h01;
               if (at_point) begin
                  // A high line here was a glitch, so go back to idle.
                  state_reg <= lnk.line ? uart_mode_pkg::ST_IDLE : uart_mode_pkg::ST_DATA;
                  cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
                  bitn_reg <= 3'h0;
                  par_reg <= 1'b0;
               end
            end
            uart_mode_pkg::ST_DATA: begin
               if (lnk.tick) cnt_reg <= cnt_reg - 6'h01;
               if (at_point) begin
                  shift_reg <= data_next;
                  par_reg <= par_reg ^ lnk.line;
                  bitn_reg <= bitn_reg + 3'h1;
                  cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
                  if (last_bit) begin
                     state_reg <= lnk.parity_en ? uart_mode_pkg::ST_PAR : uart_mode_pkg::ST_STOP;
                  end
               end
            end
            uart_mode_pkg::ST_PAR: begin
               if (lnk.tick) cnt_reg <= cnt_reg - 6'h01;
               if (at_point) begin
                  lnk.parity_err <= (par_reg ^ lnk.line) != lnk.parity_odd;
                  cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
                  state_reg <= uart_mode_pkg::ST_STOP;
               end
            end
            uart_mode_pkg::ST_STOP: begin
               if (lnk.tick) cnt_reg <= cnt_reg - 6'h01;
               // One mark check at the stop centre, whatever the stop length.
               if (at_point) begin
                  lnk.frame_err <= !lnk.line;
                  lnk.valid <= 1'b1;
                  lnk.data <= shift_reg >> (3'd3 - {1'b0, lnk.char_len});
                  if (!lnk.parity_en) lnk.parity_err <= 1'b0;
                  state_reg <= uart_mode_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_rx_stop_mid: assert property ((state_reg == uart_mode_pkg::ST_STOP) && at_point
      |=> lnk.valid)
      else $error("stop check did not report at the stop centre");
endmodule
`default_nettype wire

/* core/uart_mode_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_mode_channel (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // Serial and handshake pins.
   input wire logic serial_in_a,
   input wire logic clear_send_in_a_n,
   output logic serial_out_a,
   output logic request_send_out_a_n
);
   rx_link_if lnk ();

   // Registers seen by software.
   logic [7:0] channel_a_mode_one_reg;
   logic [7:0] channel_a_mode_two_reg;
   logic [3:0] ctrl_reg; // Transmit enable, receive enable, external 1x clock.
   logic ptr_reg; // Mode pointer: low selects mode one.
   logic output_pin_zero_reg; // Output port bit zero.
   logic [7:0] rx_hold_reg;
   logic rx_ready_reg;
   logic perr_reg;
   logic ferr_reg;
   logic [7:0] tx_hold_reg;
   logic tx_full_reg;
   // Pin synchronisers; only the second stage is read by logic.
   logic [1:0] rxd_sync_reg;
   logic [1:0] cts_sync_reg;
   wire rxd_pin = rxd_sync_reg[1];
   wire cts_high = cts_sync_reg[1];
   // 16x tick divider.
   logic [7:0] div_reg;
   wire tick = (div_reg == 8'((uart_mode_pkg::TICK_DIV) - 1));

   // Field decode.
   wire [1:0] chmode = channel_a_mode_two_reg[7:uart_mode_pkg::CHMODE_LSB];
   wire rts_ctl = channel_a_mode_two_reg[uart_mode_pkg::RTS_CTL_BIT];
   wire cts_ctl = channel_a_mode_two_reg[uart_mode_pkg::CTS_CTL_BIT];
   wire [3:0] stop_code = channel_a_mode_two_reg[uart_mode_pkg::STOP_MSB:0];
   wire tx_en = ctrl_reg[uart_mode_pkg::CTRL_TX_EN];
   wire rx_en = ctrl_reg[uart_mode_pkg::CTRL_RX_EN];
   wire ext1x = ctrl_reg[uart_mode_pkg::CTRL_EXT1X];
   wire [1:0] char_len = channel_a_mode_one_reg[1:0];
   wire [1:0] par_mode = channel_a_mode_one_reg[4:3];
   wire par_type = channel_a_mode_one_reg[2];
   wire par_en = !par_mode[1];
   // Mode decode, applied combinationally so a write acts at once.
   wire mode_echo = (chmode == uart_mode_pkg::MODE_ECHO);
   wire mode_local = (chmode == uart_mode_pkg::MODE_LOCAL);
   wire mode_remote = (chmode == uart_mode_pkg::MODE_REMOTE);
   wire echo_sel = mode_echo || mode_remote;

   // Stop length in sixteenths of a bit.
   function automatic logic [5:0] stop_len(input logic [3:0] code, input logic five,
      input logic ext);
      logic [5:0] len;
      len = code[3] ? uart_mode_pkg::STOP_LONG_BASE + 6'(code[2:0])
         : uart_mode_pkg::STOP_SHORT_BASE + 6'(code[2:0]);
      if (five && !code[3]) len = len + uart_mode_pkg::FIVE_BIT_EXTRA;
      if (ext) len = code[3] ? uart_mode_pkg::BIT_TICKS + uart_mode_pkg::BIT_TICKS
         : uart_mode_pkg::BIT_TICKS;
      return len;
   endfunction
   wire [5:0] stop_ticks = stop_len(stop_code, char_len == 2'h0, ext1x);

   // Register port decode.
   wire mode_hit = (addr == uart_mode_pkg::ADDR_MODE);
   wire wr_mode1 = wr_en && mode_hit && !ptr_reg;
   wire wr_mode2 = wr_en && mode_hit && ptr_reg;
   wire wr_ctrl = wr_en && (addr == uart_mode_pkg::ADDR_CTRL);
   wire wr_data_hit = wr_en && (addr == uart_mode_pkg::ADDR_DATA);
   wire wr_oport = wr_en && (addr == uart_mode_pkg::ADDR_OPORT);
   wire rd_data_hit = rd_en && (addr == uart_mode_pkg::ADDR_DATA);

   // Transmitter state.
   uart_mode_pkg::frame_state_t tx_state_reg;
   logic [5:0] tx_cnt_reg; // Ticks left in the current slot.
   logic [2:0] tx_bitn_reg;
   logic [7:0] tx_shift_reg;
   logic tx_par_reg; // Parity bit to send.
   logic [5:0] echo_hold_reg; // Ticks of echo left after the mode was dropped.
   logic [5:0] rts_cnt_reg; // Ticks since the transmitter went quiet.
   wire echo_act = echo_sel || (echo_hold_reg != 6'h00);
   wire tx_slot_end = tick && (tx_cnt_reg == 6'h00);
   wire tx_last = (tx_bitn_reg == {1'b0, char_len} + 3'd4);
   // Clear-to-send gate only when its control bit is set.
   wire cts_block = cts_ctl && cts_high;
   wire tx_go = tx_full_reg && tx_en && !echo_act && !cts_block;
   wire tx_idle = (tx_state_reg == uart_mode_pkg::ST_IDLE);
   wire auto_cond = rts_ctl && !tx_en && tx_idle && !tx_full_reg && output_pin_zero_reg;
   // Only the bits that are sent count towards parity, so short characters mask the rest.
   wire [7:0] char_mask = 8'hFF >> (3'd3 - {1'b0, char_len});
   wire data_par = ^(tx_hold_reg & char_mask);
   // Line level from the transmitter; marking while idle or waiting.
   wire tx_line = (tx_state_reg == uart_mode_pkg::ST_START) ? 1'b0
      : (tx_state_reg == uart_mode_pkg::ST_DATA) ? tx_shift_reg[0]
      : (tx_state_reg == uart_mode_pkg::ST_PAR) ? tx_par_reg : 1'b1;
   // Echo wins while active, then local loopback holds the pin high.
   wire serial_next = echo_act ? rxd_pin : (mode_local ? 1'b1 : tx_line);
   wire rts_auto_clr = auto_cond && tick && (rts_cnt_reg == uart_mode_pkg::BIT_TICKS - 6'h01);
   wire opr0_next = wr_oport ? wr_data[0] : (rts_auto_clr ? 1'b0 : output_pin_zero_reg);

   // Receiver link; local loopback feeds it from the transmitter.
   assign lnk.tick = tick;
   assign lnk.line = mode_local ? tx_line : rxd_pin;
   assign lnk.char_len = char_len;
   assign lnk.parity_en = par_en && !mode_remote;
   assign lnk.parity_odd = par_type;
   uart_rx_frame u_rx (
      .clock(clock),
      .rst_n(rst_n),
      .lnk(lnk)
   );
   // Remote loopback keeps data and error status from software.
   wire rx_deliver = lnk.valid && rx_en && !mode_remote;

   // Synchronisers and the tick divider.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxd_sync_reg <= 2'h3;
         cts_sync_reg <= 2'h3;
         div_reg <= 8'h00;
      end else begin
         rxd_sync_reg <= {rxd_sync_reg[0], serial_in_a};
         cts_sync_reg <= {cts_sync_reg[0], clear_send_in_a_n};
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      end
   end

   // Mode registers and their pointer.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         channel_a_mode_one_reg <= uart_mode_pkg::MODE_ONE_RST;
         channel_a_mode_two_reg <= uart_mode_pkg::MODE_TWO_RST;
         ptr_reg <= 1'b0;
         ctrl_reg <= uart_mode_pkg::CTRL_RST;
      end else begin
         if (wr_mode1) channel_a_mode_one_reg <= wr_data;
         if (wr_mode2) channel_a_mode_two_reg <= wr_data;
         // Any mode-one access moves the pointer; mode two leaves it.
         if ((wr_en || rd_en) && mode_hit && !ptr_reg) ptr_reg <= 1'b1;
         if (wr_ctrl) begin
            ctrl_reg <= {1'b0, wr_data[2:0]};
            if (wr_data[uart_mode_pkg::CTRL_PTR_RST]) ptr_reg <= 1'b0;
         end
      end
   end

   // Receive holding, status flags, and read data for the next cycle only.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_hold_reg <= 8'h00;
         rx_ready_reg <= 1'b0;
         perr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         // A new character in the read cycle wins over the clear.
         if (rd_data_hit) rx_ready_reg <= 1'b0;
         if (rx_deliver) begin
            rx_hold_reg <= lnk.data;
            rx_ready_reg <= 1'b1;
            perr_reg <= lnk.parity_err;
            ferr_reg <= lnk.frame_err;
         end
         rd_data <= 8'h00;
         if (rd_en) begin
            unique case (addr)
               uart_mode_pkg::ADDR_MODE: rd_data <= ptr_reg ? channel_a_mode_two_reg
                  : channel_a_mode_one_reg;
               uart_mode_pkg::ADDR_STATUS: rd_data <= {2'h0, ptr_reg, ferr_reg, perr_reg,
                  tx_idle && !tx_full_reg && !echo_act, !tx_full_reg && !echo_act,
                  rx_ready_reg};
               uart_mode_pkg::ADDR_CTRL: rd_data <= {4'h0, ctrl_reg};
               uart_mode_pkg::ADDR_DATA: rd_data <= rx_hold_reg;
               uart_mode_pkg::ADDR_OPORT: rd_data <= {7'h00, output_pin_zero_reg};
               default: rd_data <= 8'h00;
            endcase
         end
      end
   end

   // Output port bit, its auto clear and the pins.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         output_pin_zero_reg <= 1'b0;
         rts_cnt_reg <= 6'h00;
         request_send_out_a_n <= 1'b1;
         serial_out_a <= 1'b1;
      end else begin
         output_pin_zero_reg <= opr0_next;
         if (!auto_cond) rts_cnt_reg <= 6'h00;
         else if (tick) rts_cnt_reg <= rts_cnt_reg + 6'h01;
         request_send_out_a_n <= !opr0_next;
         serial_out_a <= serial_next;
      end
   end

   // Echo hold after the stop sample when echo is being left.
   always_ff @(posedge clock) begin
      if (!rst_n) echo_hold_reg <= 6'h00;
      else if (lnk.valid && echo_sel && tx_en) echo_hold_reg <= uart_mode_pkg::BIT_TICKS;
      else if (tick && echo_hold_reg != 6'h00) echo_hold_reg <= echo_hold_reg - 6'h01;
   end

   // Transmitter; a started character runs to its end regardless of pins.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_state_reg <= uart_mode_pkg::ST_IDLE;
         tx_cnt_reg <= 6'h00;
         tx_bitn_reg <= 3'h0;
         tx_shift_reg <= 8'h00;
         tx_par_reg <= 1'b0;
         tx_hold_reg <= 8'h00;
         tx_full_reg <= 1'b0;
      end else begin
         // Writes are dropped while the holding word is full or echo owns the line.
         if (wr_data_hit && !tx_full_reg && !echo_act) begin
            tx_hold_reg <= wr_data;
            tx_full_reg <= 1'b1;
         end
         if (tick && tx_cnt_reg != 6'h00) tx_cnt_reg <= tx_cnt_reg - 6'h01;
         unique case (tx_state_reg)
            uart_mode_pkg::ST_IDLE: begin
               if (tick && tx_go) begin
                  tx_state_reg <= uart_mode_pkg::ST_START;
                  tx_cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
                  tx_shift_reg <= tx_hold_reg;
                  tx_par_reg <= par_mode[0] ? par_type : data_par ^ par_type;
                  tx_bitn_reg <= 3'h0;
                  tx_full_reg <= 1'b0;
               end
            end
            uart_mode_pkg::ST_START: begin
               if (tx_slot_end) begin
                  tx_state_reg <= uart_mode_pkg::ST_DATA;
                  tx_cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
               end
            end
            uart_mode_pkg::ST_DATA: begin
               if (tx_slot_end) begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
                  tx_bitn_reg <= tx_bitn_reg + 3'h1;
                  tx_cnt_reg <= uart_mode_pkg::BIT_TICKS - 6'h01;
                  if (tx_last && par_en) tx_state_reg <= uart_mode_pkg::ST_PAR;
                  else if (tx_last) begin
                     tx_state_reg <= uart_mode_pkg::ST_STOP;
                     tx_cnt_reg <= stop_ticks - 6'h01;
                  end
               end
            end
            uart_mode_pkg::ST_PAR: begin
               if (tx_slot_end) begin
                  tx_state_reg <= uart_mode_pkg::ST_STOP;
                  tx_cnt_reg <= stop_ticks - 6'h01;
               end
            end
            uart_mode_pkg::ST_STOP: begin
               if (tx_slot_end) tx_state_reg <= uart_mode_pkg::ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence seq_quiet_bit;
      auto_cond && rts_auto_clr;
   endsequence
   chk_ptr_advance: assert property (wr_en && mode_hit && !ptr_reg |=> ptr_reg)
      else $error("mode pointer did not advance");
   chk_ptr_keep: assert property ((rd_en || wr_en) && mode_hit && ptr_reg && !wr_ctrl
      |=> ptr_reg)
      else $error("mode two access moved the pointer");
   chk_mode_write: assert property (wr_mode2 |=> channel_a_mode_two_reg == $past(wr_data))
      else $error("mode two write not taken at once");
   chk_rts_pin: assert property (request_send_out_a_n == !output_pin_zero_reg)
      else $error("request pin disagrees with port bit");
   chk_rts_auto: assert property (seq_quiet_bit ##0 !wr_oport |=> !output_pin_zero_reg)
      else $error("port bit not cleared after quiet bit time");
   chk_rts_manual: assert property (!rts_ctl && !wr_oport && output_pin_zero_reg
      |=> output_pin_zero_reg)
      else $error("port bit changed without auto control");
   chk_cts_wait: assert property (tx_idle && cts_ctl && cts_high |=> tx_idle)
      else $error("character started while clear-to-send high");
   chk_local_high: assert property (mode_local && !echo_act |=> serial_out_a)
      else $error("serial output not high in local loopback");
   chk_stop_load: assert property ($rose(tx_state_reg == uart_mode_pkg::ST_STOP)
      |-> tx_cnt_reg == $past(stop_ticks) - 6'h01)
      else $error("stop length not loaded");
endmodule
`default_nettype wire

/* tb/uart_peer.sv */
`timescale 1ns/10ps
`default_nettype none
// Far-end transceiver wired to the channel's serial and handshake pins.
module uart_peer #(
   parameter int BIT_CLKS = 16 * uart_mode_pkg::TICK_DIV
) (
   // Clock.
   input wire logic clock,
   // Lines towards the channel.
   input wire logic line_in,
   output logic line_out,
   output logic cts_n
);
   logic [7:0] got_byte; // Last character decoded from the channel.
   // Lines start idle: marking and clear to send.
   initial begin
      line_out = 1'b1;
      cts_n = 1'b0;
      got_byte = 8'h00;
   end
   // Sends one 8-bit character LSB first with one stop bit.
   task automatic send_byte(input logic [7:0] value);
      for (int i = 0; i < 10; i++) begin
         line_out <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : value[i - 1]);
         repeat (BIT_CLKS) @(posedge clock);
      end
   endtask
   // Samples at bit centres, so a few clocks of skew cannot corrupt a bit.
   always begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clock);
         got_byte[i] = line_in;
      end
   end
endmodule
`default_nettype wire

/* tb/tb_uart_channel_mode_flow_stop.sv */
`timescale 1ns/10ps
`default_nettype none
// Checks the mode register two behaviour of the channel at its pins.
module tb_uart_channel_mode_flow_stop;
   localparam int TICK = uart_mode_pkg::TICK_DIV; // Clocks per sixteenth of a bit.
   localparam int BIT = 16 * TICK; // Clocks per bit.
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] rd_data;
   wire logic serial_in_a;
   wire logic clear_send_in_a_n;
   logic serial_out_a;
   logic request_send_out_a_n;
   int bad_count = 0;
   int checks = 0;
   int cycle_count = 0; // Also the time base for frame lengths.
   uart_mode_channel dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_in_a(serial_in_a),
      .clear_send_in_a_n(clear_send_in_a_n), .serial_out_a(serial_out_a),
      .request_send_out_a_n(request_send_out_a_n));
   uart_peer peer (.clock(clock), .line_in(serial_out_a), .line_out(serial_in_a),
      .cts_n(clear_send_in_a_n));
   // 100 MHz clock.
   always #5 clock = ~clock;
   // Cuts a hang short; the ceiling leaves room above the longest expected run.
   always @(posedge clock) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 95000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle strobes with a gap, so no signal is assigned twice in a step.
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
      @(posedge clock);
   endtask
   // Pointer back to mode one, then both mode words; this also disables both directions.
   task automatic set_modes(input logic [7:0] m1, input logic [7:0] m2);
      // A stale character in the peer must not satisfy the next scenario's check.
      peer.got_byte = 8'h00;
      reg_write(8'h08, 8'h08);
      reg_write(8'h00, m1);
      reg_write(8'h00, m2);
   endtask
   task automatic test_pointer;
      logic [7:0] d;
      set_modes(8'h13, 8'h07);
      reg_read(8'h04, d);
      check(d & 8'h20, 8'h20);
      reg_read(8'h00, d);
      check(d, 8'h07);
      reg_read(8'h00, d);
      check(d, 8'h07);
      reg_read(8'h14, d);
      check(d, 8'h00);
      reg_write(8'h08, 8'h08);
      reg_read(8'h00, d);
      check(d, 8'h13);
   endtask
   // Without automatic control the idle transmitter must leave the port bit alone.
   task automatic test_rts_pin;
      logic [7:0] d;
      reg_write(8'h10, 8'h01);
      repeat (2 * BIT) @(posedge clock);
      check({7'h00, request_send_out_a_n}, 8'h00);
      reg_read(8'h10, d);
      check(d, 8'h01);
      reg_write(8'h10, 8'h00);
      repeat (2) @(posedge clock);
      check({7'h00, request_send_out_a_n}, 8'h01);
   endtask
   // Start bit to pin release must be the frame plus one bit, in sixteenths.
   task automatic test_frame(input logic [7:0] m1, input logic [3:0] code,
         input logic cts_ctl, input logic ext, input int exp, input logic whole);
      int t0;
      int n;
      logic held;
      held = 1'b0;
      n = 0;
      set_modes(m1, {2'b00, 1'b1, cts_ctl, code});
      // Clear-to-send goes high well before the load, so the gate sees it settled.
      peer.cts_n <= 1'b1;
      reg_write(8'h08, {5'h00, ext, 2'b01});
      reg_write(8'h10, 8'h01);
      reg_write(8'h0C, 8'hA5);
      if (cts_ctl) begin
         repeat (3 * BIT) begin
            @(posedge clock);
            held = held | (serial_out_a !== 1'b1);
         end
         check({7'h00, held}, 8'h00);
         peer.cts_n <= 1'b0;
      end
      while (serial_out_a !== 1'b0 && n < 4 * BIT) begin
         @(posedge clock);
         n++;
      end
      check({7'h00, n < 2 * TICK + 4}, 8'h01);
      t0 = cycle_count;
      reg_write(8'h08, {5'h00, ext, 2'b00});
      peer.cts_n <= 1'b1;
      n = 0;
      while (request_send_out_a_n !== 1'b1 && n < 16 * BIT) begin
         @(posedge clock);
         n++;
      end
      // The start is seen one clock late, so round to the nearest sixteenth.
      n = (cycle_count - t0 + TICK / 2) / TICK;
      check(8'(n), 8'(exp));
      if (whole) check(peer.got_byte, 8'hA5);
      peer.cts_n <= 1'b0;
      repeat (BIT) @(posedge clock);
   endtask
   // Echo and remote loopback both return the character; only echo delivers it,
   // so the word held from the echo run must survive the remote run.
   task automatic test_echo(input logic [7:0] m2, input logic [7:0] ready,
         input logic [7:0] value);
      logic [7:0] d;
      set_modes(8'h13, m2);
      reg_write(8'h08, 8'h03);
      peer.send_byte(value);
      check(peer.got_byte, value);
      // Let the echo hold after the stop sample run out before the next scenario.
      repeat (BIT) @(posedge clock);
      reg_read(8'h04, d);
      check(d & 8'h01, ready);
      reg_read(8'h0C, d);
      check(d, 8'h3C);
   endtask
   // Local loopback keeps the pin marking while the character reaches the receiver.
   task automatic test_local;
      logic [7:0] d;
      logic moved;
      moved = 1'b0;
      set_modes(8'h13, 8'h80);
      reg_write(8'h08, 8'h03);
      reg_write(8'h0C, 8'h5A);
      repeat (12 * BIT) begin
         @(posedge clock);
         moved = moved | (serial_out_a !== 1'b1);
      end
      check({7'h00, moved}, 8'h00);
      reg_read(8'h0C, d);
      check(d, 8'h5A);
   endtask
   // Main sequence.
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      test_pointer();
      test_rts_pin();
      test_frame(8'h13, 4'h0, 1'b0, 1'b0, 144 + 9 + 16, 1'b1);
      test_frame(8'h13, 4'hF, 1'b1, 1'b0, 144 + 32 + 16, 1'b1);
      test_frame(8'h13, 4'h8, 1'b0, 1'b0, 144 + 25 + 16, 1'b1);
      test_frame(8'h13, 4'hB, 1'b0, 1'b1, 144 + 32 + 16, 1'b1);
      test_frame(8'h10, 4'h0, 1'b0, 1'b0, 96 + 17 + 16, 1'b0);
      test_echo(8'h40, 8'h01, 8'h3C);
      test_echo(8'hC0, 8'h00, 8'hC3);
      test_local();
      wrap_up();
   end
endmodule
`default_nettype wire
